// ==== hw/fp_error_reporting.sv ====
// Floating-point error reporting: status flags, native trap and compatibility pin.
// Assumes a classic Wishbone master and an issue port that holds a request until answered.
//
// Contract
// - Native reporting is used while bit 5 of the control register holds 1.
// - An unmasked exception sets its flag and the error summary flag.
// - In native mode a pending error traps with vector 16 before the next waiting instruction.
// - Non-waiting instructions run without taking a pending error trap.
// - With the mode bit at 0 errors are reported through the pin and input signals.
// - In compatibility mode the error pin asserts at once or at the next waiting instruction.
// - In compatibility mode a waiting instruction stalls while an unmasked flag is pending.
// - While the ignore input is asserted error conditions cause no pin and no stall.
// - The address of the faulting instruction is kept for software to read.
// - A masked exception gives the default result and no trap or pin.
// - Init, clear, store-environment and save discard pending errors.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module fp_error_reporting (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic instr_valid,
  input fp_err_pkg::instr_class_e instr_class,
  input wire logic exc_valid,
  input wire logic [fp_err_pkg::NUM_EXC-1:0] exc_flags,
  input wire logic [31:0] exc_addr,
  input wire logic ignore_numeric_error_in_n,
  input wire logic interrupt_request_in,
  output logic instr_accept,
  output logic instr_stalled,
  output logic fp_error_exception,
  output logic [7:0] fp_error_vector,
  output logic masked_default,
  output logic fp_error_out_n
);
  import fp_err_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [NUM_EXC-1:0] mask_q, mask_d;
  logic [NUM_EXC-1:0] flags_q, flags_d;
  logic summary_q, summary_d;
  logic [31:0] fault_addr_q, fault_addr_d;
  logic ign_meta_q, ign_meta_d, ign_sync_n_q, ign_sync_n_d;
  logic req_meta_q, req_meta_d, req_sync_q, req_sync_d;
  issue_state_e st_q, st_d;
  logic stall_q, stall_d;
  logic accept_q, accept_d, trap_q, trap_d;
  logic [7:0] vector_q, vector_d;
  logic masked_q, masked_d;
  logic pin_on_q, pin_on_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic dec_waiting, dec_nowait, dec_clears, dec_masks;
  logic native, ignore_on, evaluate, new_unmasked, bus_write;
  logic [NUM_EXC-1:0] clr_flags;
  logic set_mask_all;

  fp_instr_decode u_decode (
    .instr_class(instr_class),
    .is_waiting(dec_waiting),
    .is_nowait(dec_nowait),
    .clears_flags(dec_clears),
    .masks_all(dec_masks)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    ign_meta_d = ignore_numeric_error_in_n;
    ign_sync_n_d = ign_meta_q;
    req_meta_d = interrupt_request_in;
    req_sync_d = req_meta_q;
    native = ctrl_q[CTRL_MODE_BIT];
    // ignore input honoured only in compatibility mode
    ignore_on = !native && !ign_sync_n_q;
    evaluate = (st_q == S_IDLE && instr_valid) || (st_q == S_STALL);
    bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    new_unmasked = exc_valid && ((exc_flags & ~mask_q) != 6'h00);

    ctrl_d = ctrl_q;
    mask_d = mask_q;
    clr_flags = 6'h00;
    set_mask_all = 1'b0;
    st_d = st_q;
    accept_d = 1'b0;
    trap_d = 1'b0;
    vector_d = vector_q;
    pin_on_d = pin_on_q;

    if (bus_write && wb_adr_i == OFS_CTRL) begin
      ctrl_d = wb_dat_i[7:0];
    end
    if (bus_write && wb_adr_i == OFS_STATUS) begin
      clr_flags = wb_dat_i[NUM_EXC-1:0];
    end

    case (st_q)
      S_IDLE: begin
        if (instr_valid) begin
          if (dec_nowait || !dec_waiting || !summary_q) begin
            // non-waiting instructions pass a pending error
            accept_d = 1'b1;
            st_d = S_DONE;
            if (dec_clears) begin
              clr_flags = MASK_ALL;
            end
            set_mask_all = dec_masks;
          end else if (native) begin
            trap_d = 1'b1;
            vector_d = FP_ERROR_VECTOR;
            st_d = S_DONE;
          end else if (ignore_on) begin
            accept_d = 1'b1;
            st_d = S_DONE;
          end else begin
            st_d = S_STALL;
          end
        end
      end
      S_STALL: begin
        if (native && summary_q) begin
          trap_d = 1'b1;
          vector_d = FP_ERROR_VECTOR;
          st_d = S_DONE;
        end else if (!summary_q || ignore_on) begin
          accept_d = 1'b1;
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase

    if (bus_write && wb_adr_i == OFS_MASK) begin
      mask_d = wb_dat_i[NUM_EXC-1:0];
    end
    if (set_mask_all) begin
      mask_d = MASK_ALL;
    end

    // Set wins over clear so an exception in the clearing cycle is kept.
    flags_d = (flags_q & ~clr_flags) | (exc_valid ? exc_flags : 6'h00);
    // summary holds while an unmasked flag remains
    summary_d = new_unmasked || (summary_q && ((flags_d & ~mask_d) != 6'h00));

    fault_addr_d = new_unmasked ? exc_addr : fault_addr_q;

    // masked exception gives the default result only
    masked_d = exc_valid && (exc_flags != 6'h00) && !new_unmasked;

    // external pin only in compatibility mode
    pin_on_d = !native && summary_d && (pin_on_q ||
               (!ignore_on && new_unmasked && ctrl_q[CTRL_IMMEDIATE_BIT]) ||
               (!ignore_on && evaluate && dec_waiting && summary_q));

    // The stall output gets its own flop so the core sees no decode glitch.
    stall_d = (st_d == S_STALL);

    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdata_d = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
      case (wb_adr_i)
        OFS_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        OFS_STATUS: rdata_d = {24'h00_0000, summary_q, 1'b0, flags_q};
        OFS_MASK: rdata_d = {26'h000_0000, mask_q};
        OFS_FAULT_ADDR: rdata_d = fault_addr_q;
        OFS_STATE: rdata_d = {28'h000_0000, req_sync_q, !ign_sync_n_q, pin_on_q,
                              st_q == S_STALL};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
      flags_q <= FLAGS_RESET;
      summary_q <= 1'b0;
      fault_addr_q <= ADDR_RESET;
      ign_meta_q <= 1'b1;
      ign_sync_n_q <= 1'b1;
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      st_q <= S_IDLE;
      stall_q <= 1'b0;
      accept_q <= 1'b0;
      trap_q <= 1'b0;
      vector_q <= 8'h00;
      masked_q <= 1'b0;
      pin_on_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      flags_q <= flags_d;
      summary_q <= summary_d;
      fault_addr_q <= fault_addr_d;
      ign_meta_q <= ign_meta_d;
      ign_sync_n_q <= ign_sync_n_d;
      req_meta_q <= req_meta_d;
      req_sync_q <= req_sync_d;
      st_q <= st_d;
      stall_q <= stall_d;
      accept_q <= accept_d;
      trap_q <= trap_d;
      vector_q <= vector_d;
      masked_q <= masked_d;
      pin_on_q <= pin_on_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // The pin is active low and stays high while no error is reported.
  assign fp_error_out_n = !pin_on_q;
  assign instr_accept = accept_q;
  assign fp_error_exception = trap_q;
  assign fp_error_vector = vector_q;
  assign masked_default = masked_q;
  assign instr_stalled = stall_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // native trap timing
  native_trap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (st_q == S_IDLE && instr_valid && dec_waiting && !dec_nowait && summary_q && native)
    |=> (fp_error_exception && !instr_accept && fp_error_vector == FP_ERROR_VECTOR))
    else $error("native trap not raised");

  nowait_pass_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (st_q == S_IDLE && instr_valid && dec_nowait) |=> (instr_accept && !fp_error_exception))
    else $error("nowait instruction not accepted");

  compat_stall_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (st_q == S_IDLE && instr_valid && dec_waiting && summary_q && !native && !ignore_on)
    |=> (instr_stalled && !instr_accept))
    else $error("waiting instruction not stalled");

  summary_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    new_unmasked |=> (summary_q && (flags_q & $past(exc_flags)) == $past(exc_flags)))
    else $error("summary flag not set");

  native_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(native) |-> fp_error_out_n)
    else $error("error pin driven in native mode");

  deferred_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (instr_stalled && !native && summary_q && !ignore_on) |-> ##[0:1] !fp_error_out_n)
    else $error("error pin not asserted at stall");

  ignore_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ignore_on && !pin_on_q) |=> fp_error_out_n)
    else $error("error pin asserted while ignored");

  masked_quiet_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (exc_valid && exc_flags != 6'h00 && !new_unmasked && !summary_q)
    |=> (masked_default && !summary_q))
    else $error("masked exception raised an error");

  summary_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (summary_q && ((flags_q & ~mask_q) != 6'h00) && !(wb_cyc_i && wb_stb_i && wb_we_i)
     && !(instr_valid && (dec_clears || dec_masks))) |=> summary_q)
    else $error("summary flag dropped early");

  fault_addr_a: assert property (@(posedge core_clk) disable iff (!resetn)
    new_unmasked |=> fault_addr_q == $past(exc_addr))
    else $error("fault address not captured");

endmodule

// ==== include/fp_err_pkg.sv ====
// Shared constants and types of the floating-point error reporting block.
// Assumes a 32-bit classic Wishbone register bus and an instruction issue port on core_clk.
package fp_err_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int NUM_EXC = 6;
  localparam int CTRL_IMMEDIATE_BIT = 0;
  localparam int CTRL_MODE_BIT = 5;
  localparam int STATUS_SUMMARY_BIT = 7;
  localparam int STATE_STALL_BIT = 0;
  localparam int STATE_PIN_BIT = 1;
  localparam int STATE_IGNORE_BIT = 2;
  localparam int STATE_REQ_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h3F;
  localparam logic [5:0] MASK_ALL = 6'h3F;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [7:0] FP_ERROR_VECTOR = 8'h10;

  // ----------------------------------------------------------------
  // Instruction classes presented by the core
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IC_OTHER = 4'h0,
    IC_FP_WAITING = 4'h1,
    IC_WAIT = 4'h2,
    IC_SIMD = 4'h3,
    IC_INIT_NOWAIT = 4'h4,
    IC_CLEX_NOWAIT = 4'h5,
    IC_STSW_NOWAIT = 4'h6,
    IC_STCW_NOWAIT = 4'h7,
    IC_STENV_NOWAIT = 4'h8,
    IC_SAVE_NOWAIT = 4'h9
  } instr_class_e;

  // ----------------------------------------------------------------
  // Issue state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_STALL = 3'b010,
    S_DONE = 3'b100
  } issue_state_e;

endpackage

// ==== hw/fp_instr_decode.sv ====
// Decodes an instruction class into the properties the error logic needs.
// Assumes the class comes from logic on the same clock; purely combinational.
`timescale 1ns/1ps
module fp_instr_decode (
  input fp_err_pkg::instr_class_e instr_class,
  output logic is_waiting,
  output logic is_nowait,
  output logic clears_flags,
  output logic masks_all
);
  import fp_err_pkg::*;

  always_comb begin
    is_waiting = 1'b0;
    is_nowait = 1'b0;
    clears_flags = 1'b0;
    masks_all = 1'b0;
    case (instr_class)
      IC_FP_WAITING, IC_WAIT, IC_SIMD: begin
        is_waiting = 1'b1;
      end
      IC_INIT_NOWAIT: begin
        is_nowait = 1'b1;
        clears_flags = 1'b1;
        masks_all = 1'b1;
      end
      IC_CLEX_NOWAIT: begin
        is_nowait = 1'b1;
        clears_flags = 1'b1;
      end
      IC_STENV_NOWAIT, IC_SAVE_NOWAIT: begin
        is_nowait = 1'b1;
        masks_all = 1'b1;
      end
      IC_STSW_NOWAIT, IC_STCW_NOWAIT: begin
        is_nowait = 1'b1;
      end
      default: begin
        is_nowait = 1'b0;
      end
    endcase
  end

endmodule

// ==== tb/fp_pic_model.sv ====
// Model of the outside interrupt controller and the glue behind the error pin.
// Assumes the error pin is active low and is sampled on core_clk.
`timescale 1ns/1ps
module fp_pic_model #(
  parameter int LATENCY = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fp_error_out_n,
  output logic interrupt_request_in,
  output logic [7:0] int_vector
);
  // ----------------------------------------------------------------
  // Request path
  // ----------------------------------------------------------------
  // A longer LATENCY models a slow controller; it must stay 2 or more.
  localparam int REQ_LINE = 13;
  localparam logic [7:0] SLAVE_BASE = 8'h70;
  logic [LATENCY-1:0] req_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) req_q <= '0;
    else req_q <= {req_q[LATENCY-2:0], ~fp_error_out_n};
  end
  assign interrupt_request_in = req_q[LATENCY-1];
  assign int_vector = interrupt_request_in ? SLAVE_BASE + 8'(REQ_LINE - 8) : 8'h00;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the floating-point error reporting block.
// Assumes a classic Wishbone master and a core issue port driven by this bench.
`timescale 1ns/1ps
module testbench;
  import fp_err_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exc_addr = 32'h0, rd;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, instr_valid = 1'b0, exc_valid = 1'b0, ign_n = 1'b1, int_req;
  instr_class_e instr_class = IC_OTHER;
  logic [5:0] exc_flags = 6'h00;
  logic acc, stl, trap, mdef, pin_n;
  logic [7:0] vec, pic_vec;
  int fails = 0, num_checks = 0;
  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  fp_error_reporting DUT (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .instr_valid(instr_valid), .instr_class(instr_class), .exc_valid(exc_valid),
    .exc_flags(exc_flags), .exc_addr(exc_addr), .ignore_numeric_error_in_n(ign_n),
    .interrupt_request_in(int_req), .instr_accept(acc), .instr_stalled(stl),
    .fp_error_exception(trap), .fp_error_vector(vec), .masked_default(mdef),
    .fp_error_out_n(pin_n));
  fp_pic_model #(.LATENCY(3)) pic (.core_clk(core_clk), .resetn(resetn),
    .fp_error_out_n(pin_n), .interrupt_request_in(int_req), .int_vector(pic_vec));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, exp);
  endtask
  task automatic exc(input logic [5:0] f, input logic [31:0] a);
    @(posedge core_clk);
    exc_valid <= 1'b1; exc_flags <= f; exc_addr <= a;
    @(posedge core_clk);
    exc_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic go(input instr_class_e c);
    @(posedge core_clk);
    instr_valid <= 1'b1; instr_class <= c;
  endtask
  // Returns 1 for accept, 2 for trap, with the vector in bits 15:8 taken at the same edge.
  task automatic done_wait(output logic [31:0] r);
    do @(posedge core_clk); while (acc !== 1'b1 && trap !== 1'b1);
    r = {16'h0000, vec, 6'h00, trap, acc};
    instr_valid <= 1'b0;
  endtask
  task automatic issue(input instr_class_e c, input logic [31:0] exp);
    go(c);
    done_wait(rd);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // The sequence needs well under 1000 cycles, so 50 us means a hang.
  initial begin
    #50000;
    fails++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(OFS_CTRL, 32'h00);
    rdchk(OFS_MASK, 32'h3F);
    rdchk(8'h14, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h20, 4'h0);
    rdchk(OFS_CTRL, 32'h00);
    exc(6'h01, 32'h100);
    chk({mdef, pin_n}, 2'b11);
    rdchk(OFS_STATUS, 32'h01);
    wb(1'b1, OFS_STATUS, 32'h3F, 4'h1);
    wb(1'b1, OFS_MASK, 32'h00, 4'h1);
    exc(6'h04, 32'h2A4);
    chk({mdef, pin_n}, 2'b01);
    rdchk(OFS_STATUS, 32'h84);
    rdchk(OFS_FAULT_ADDR, 32'h2A4);
    issue(IC_STSW_NOWAIT, 32'h1);
    go(IC_WAIT);
    repeat (10) @(posedge core_clk);
    chk({stl, pin_n, pic_vec}, {2'b10, 8'h75});
    rdchk(OFS_STATE, 32'h0B);
    wb(1'b1, OFS_STATUS, 32'h04, 4'h1);
    done_wait(rd);
    chk(rd, 32'h1);
    @(posedge core_clk);
    chk({stl, pin_n}, 2'b01);
    ign_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    exc(6'h02, 32'h300);
    issue(IC_FP_WAITING, 32'h1);
    chk(pin_n, 1'b1);
    rdchk(OFS_STATUS, 32'h82);
    ign_n <= 1'b1;
    issue(IC_CLEX_NOWAIT, 32'h1);
    rdchk(OFS_STATUS, 32'h00);
    wb(1'b1, OFS_CTRL, 32'h01, 4'h1);
    exc(6'h08, 32'h400);
    chk(pin_n, 1'b0);
    issue(IC_STCW_NOWAIT, 32'h1);
    issue(IC_OTHER, 32'h1);
    rdchk(OFS_STATUS, 32'h88);
    issue(IC_STENV_NOWAIT, 32'h1);
    rdchk(OFS_STATUS, 32'h08);
    chk(pin_n, 1'b1);
    issue(IC_SIMD, 32'h1);
    wb(1'b1, OFS_MASK, 32'h00, 4'h1);
    wb(1'b1, OFS_CTRL, 32'h20, 4'h1);
    exc(6'h01, 32'h480);
    issue(IC_SIMD, 32'h1002);
    wb(1'b1, OFS_STATUS, 32'h3F, 4'h1);
    exc(6'h10, 32'h500);
    chk(pin_n, 1'b1);
    issue(IC_SAVE_NOWAIT, 32'h1001);
    rdchk(OFS_MASK, 32'h3F);
    wb(1'b1, OFS_MASK, 32'h00, 4'h1);
    exc(6'h20, 32'h600);
    issue(IC_WAIT, 32'h1002);
    issue(IC_INIT_NOWAIT, 32'h1001);
    rdchk(OFS_STATUS, 32'h00);
    issue(IC_FP_WAITING, 32'h1001);
    test_done;
  end
endmodule
